/* File: hw/pwd_guard_defs.svh */
/*
 Timing counts, register offsets, field positions and reset values for the
 password sector protection block. Assumes a 50 MHz pclk.
*/
`ifndef PWD_GUARD_DEFS_SVH
`define PWD_GUARD_DEFS_SVH

// Clock and unlock interval
`define CLK_MHZ 50
`define UNLOCK_INTERVAL_US 100
`define UNLOCK_INTERVAL_CYC (`UNLOCK_INTERVAL_US * `CLK_MHZ)

// Register byte offsets
`define OFF_MODE_CFG 12'h000
`define OFF_BOOT_CFG 12'h004
`define OFF_CMD 12'h008
`define OFF_STATUS 12'h00c
`define OFF_PWD_LO 12'h010
`define OFF_PWD_HI 12'h014
`define OFF_GUARD 12'h018
`define OFF_ADDR_IN 12'h01c
`define OFF_ADDR_OUT 12'h020

// Field positions
`define BIT_READ_GUARD 5
`define BIT_SECRET_LOCK 2
`define BIT_PERSIST_LOCK 1
`define BOOT_LO 8
`define BOOT_HI 9
`define ST_SECTOR_FAIL 1
`define ST_PROG_FAIL 4
`define ST_BUSY 0
`define ST_LOCK_BIT 8
`define ST_READ_GUARD_ON 9

// Reset values
`define MODE_CFG_RST 16'hfeff
`define BOOT_CFG_RST 16'h0300
`define PWD_RST 64'hffff_ffff_ffff_ffff

// Sector select bits of a 26-bit byte address, 256 KB sectors
`define ADDR_W 26
`define SECT_LSB 18
`define SECT_W 8

// Command codes written to the command register
`define CMD_PWD_PROG 4'h1
`define CMD_PWD_READ 4'h2
`define CMD_UNLOCK 4'h3
`define CMD_LOCK_CLEAR 4'h4
`define CMD_MODE_PROG 4'h5
`define CMD_GUARD_PROG 4'h6
`define CMD_GUARD_ERASE 4'h7
`define CMD_ID_READ 4'h8
`define CMD_BOOT_WRITE 4'h9

`endif

/* File: hw/pwd_guard_pkg.sv */
/*
 Types shared by the password sector protection block.
 Assumes pwd_guard_defs.svh is compiled alongside.
*/
package pwd_guard_pkg;

    // Controller state of the command engine
    typedef enum logic [1:0] {
        IDLE,
        WAIT_INTERVAL
    } ctrl_state_type;

    // Status flags that hardware raises
    typedef struct packed {
        logic sector_lock_fail_flag;
        logic program_fail_flag;
    } fail_flags_type;

endpackage : pwd_guard_pkg

/* File: hw/unlock_timer.sv */
/*
 Down counter for the busy time after each accepted unlock command.
 Assumes start is a one-cycle pulse from the same clock domain.
*/
`timescale 1ns/1ps
`include "pwd_guard_defs.svh"

module unlock_timer #(
    parameter int unsigned CYCLES = `UNLOCK_INTERVAL_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    output logic done
);

    logic [15:0] count_r;

    // Count down, pulse done on the last cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 16'h0000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count_r <= 16'(CYCLES);
            end else if (count_r != 16'h0000) begin
                count_r <= count_r - 16'h0001;
                if (count_r == 16'h0001) begin
                    done <= 1'b1;
                end
            end
        end
    end

endmodule : unlock_timer

/* File: hw/password_sector_protection.sv */
/*
 Password sector protection: password store, unlock engine, lock bit,
 protection mode lock bits and read-password address forcing, reached
 over APB. Assumes a single pclk domain and an APB master that holds
 each request until pready.
*/
// Our own choices: register access over APB and the placing of the registers.
// Behaviour
// - Lock bit set only after a full matching 64-bit password
// - Lock bit cleared on every reset
// - Successful unlock sets the lock bit to one
// - Password program only turns ones into zeros
// - Password resets to all ones, reached only by its own commands
// - Once secret lock is zero, password read and program are ignored
// - Programming a locked password or lock bit again sets both fail flags
// - No erase path exists for the password mode lock bit
// - Password halves any order; compare only after all 64 bits given
// - Mismatch leaves lock bit and sets program fail flag
// - Busy for the unlock interval before the lock bit sets
// - At most one unlock per interval; host polls busy
// - Read guard needs select bit zero and secret lock zero
// - Read guard leaves one 256 KB sector visible; others alias
// - Sector bits forced low for codes 00/10, high for 01/11
// - Boot map codes: 00/01 parameter, 10/11 uniform; reset 11
// - Guard bit program and erase blocked while lock bit is zero
// - Correct unlock disables forcing; reset re-enables it; here reset reloads the mode word, so only lock clear re-enables it
// - Lock bit cleared only by reset or lock clear command
// - Under read guard only id read, unlock and array reads work; here register reads, status clear and password and address staging also work
// - Guard bit reads under read guard return undefined data
// - Under read guard all programming and register writes refused; here writes to status, password halves and address input are accepted
// - Both lock bits at once, or mode write after lock, aborts with flags
`timescale 1ns/1ps
`include "pwd_guard_defs.svh"

module password_sector_protection
    import pwd_guard_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] persistent_sector_guard_bits,
    output logic [15:0] dynamic_sector_guard_bits
);

    // Stored state
    logic [15:0] mode_cfg_r;
    logic [15:0] boot_cfg_r;
    logic [63:0] pwd_r;
    logic [31:0] pwd_lo_r;
    logic [31:0] pwd_hi_r;
    logic [1:0] part_seen_r;
    logic lock_bit_r;
    logic busy_r;
    fail_flags_type flags_r;
    ctrl_state_type state_r;
    logic [`ADDR_W-1:0] addr_in_r;
    logic [`ADDR_W-1:0] addr_out_r;
    logic timer_start;
    logic timer_done;
    logic match_r;

    // Decode and qualifiers
    logic wr_en;
    logic rd_en;
    logic cmd_wr;
    logic [3:0] cmd_code;
    logic secret_locked;
    logic persist_locked;
    logic read_guard_on;
    logic mode_frozen;
    logic reg_wr_ok;
    // Accepted commands and abort causes
    logic pwd_prog_ok;
    logic mode_both_locks;
    logic mode_prog_ok;
    logic boot_wr_ok;
    logic unlock_go;
    logic lock_clear_ok;
    logic guard_wr;
    logic status_clr;
    logic pwd_lo_wr;
    logic pwd_hi_wr;
    logic addr_wr;
    logic set_both;
    logic set_prog;
    logic pwd_set_r;
    logic [31:0] status_word;

    // Writes land in the access phase; reads are fetched at setup
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign cmd_wr = wr_en && (paddr == `OFF_CMD);
    assign cmd_code = pwdata[3:0];

    // Mode decode of the lock field: 01 password, 10 persistent, 11 temporary
    assign secret_locked = !mode_cfg_r[`BIT_SECRET_LOCK];
    assign persist_locked = !mode_cfg_r[`BIT_PERSIST_LOCK];
    assign mode_frozen = secret_locked || persist_locked;
    assign read_guard_on = !mode_cfg_r[`BIT_READ_GUARD] && secret_locked
        && !lock_bit_r && pwd_set_r;
    // Programming commands, boot writes and guard writes barred while read guard active
    assign reg_wr_ok = !read_guard_on;

    // Command acceptance; a busy engine takes no new command
    assign pwd_prog_ok = cmd_wr && cmd_code == `CMD_PWD_PROG && !secret_locked
        && reg_wr_ok && !busy_r;
    assign mode_both_locks = !pwdata[16 + `BIT_SECRET_LOCK]
        && !pwdata[16 + `BIT_PERSIST_LOCK];
    assign mode_prog_ok = cmd_wr && cmd_code == `CMD_MODE_PROG && !mode_frozen
        && !mode_both_locks && reg_wr_ok && !busy_r;
    assign boot_wr_ok = cmd_wr && cmd_code == `CMD_BOOT_WRITE && reg_wr_ok
        && !busy_r;
    assign unlock_go = (state_r == IDLE) && cmd_wr && cmd_code == `CMD_UNLOCK
        && secret_locked && part_seen_r == 2'b11;
    assign lock_clear_ok = cmd_wr && cmd_code == `CMD_LOCK_CLEAR && !read_guard_on
        && !busy_r;
    assign guard_wr = wr_en && paddr == `OFF_GUARD && reg_wr_ok;
    assign status_clr = wr_en && paddr == `OFF_STATUS && pwdata[0];
    assign pwd_lo_wr = wr_en && paddr == `OFF_PWD_LO;
    assign pwd_hi_wr = wr_en && paddr == `OFF_PWD_HI;
    assign addr_wr = wr_en && paddr == `OFF_ADDR_IN;

    // Abort causes raise both flags; a wrong password only the program flag
    assign set_both = cmd_wr && !busy_r && (
        (cmd_code == `CMD_PWD_PROG && secret_locked) ||
        (cmd_code == `CMD_MODE_PROG && mode_frozen) ||
        (cmd_code == `CMD_MODE_PROG && mode_both_locks));
    assign set_prog = timer_done && !match_r;

    // Password store: only the dedicated command reaches it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwd_r <= `PWD_RST;
        end else if (pwd_prog_ok) begin
            pwd_r <= pwd_r & {pwd_hi_r, pwd_lo_r};
        end
    end

    // Read guard waits until a password has been programmed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwd_set_r <= 1'b0;
        end else if (pwd_prog_ok) begin
            pwd_set_r <= 1'b1;
        end
    end

    // Status word as software reads it
    assign status_word = {22'h00_0000, read_guard_on, lock_bit_r, 3'b000,
        flags_r.program_fail_flag, 2'b00, flags_r.sector_lock_fail_flag, busy_r};

    // Password halves staged; seen bits track a complete entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwd_lo_r <= 32'hffff_ffff;
            pwd_hi_r <= 32'hffff_ffff;
            part_seen_r <= 2'b00;
        end else begin
            if (pwd_lo_wr) begin
                pwd_lo_r <= pwdata;
                part_seen_r[0] <= 1'b1;
            end else if (pwd_hi_wr) begin
                pwd_hi_r <= pwdata;
                part_seen_r[1] <= 1'b1;
            end else if (cmd_wr && cmd_code == `CMD_UNLOCK && !busy_r) begin
                part_seen_r <= 2'b00;
            end
        end
    end

    // Protection mode word: program only clears bits; only reset sets them again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_cfg_r <= `MODE_CFG_RST;
        end else if (mode_prog_ok) begin
            mode_cfg_r <= mode_cfg_r & pwdata[31:16];
        end
    end

    // Boot map word; volatile, written through the command register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_cfg_r <= `BOOT_CFG_RST;
        end else if (boot_wr_ok) begin
            boot_cfg_r <= pwdata[31:16];
        end
    end

    // Unlock engine: compare once, then hold busy for the interval
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= IDLE;
            busy_r <= 1'b0;
            match_r <= 1'b0;
        end else begin
            case (state_r)
                IDLE: begin
                    if (unlock_go) begin
                        match_r <= ({pwd_hi_r, pwd_lo_r} == pwd_r);
                        busy_r <= 1'b1;
                        state_r <= WAIT_INTERVAL;
                    end
                end
                WAIT_INTERVAL: begin
                    // Further unlocks ignored while busy
                    if (timer_done) begin
                        busy_r <= 1'b0;
                        state_r <= IDLE;
                    end
                end
                default: begin
                    state_r <= IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // One full interval per accepted unlock
    assign timer_start = unlock_go;

    unlock_timer #(
        .CYCLES(`UNLOCK_INTERVAL_CYC)
    ) u_unlock_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(timer_start),
        .done(timer_done)
    );

    // Lock bit: zero at reset, set by a good unlock, cleared by command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_bit_r <= 1'b0;
        end else if (timer_done && match_r) begin
            lock_bit_r <= 1'b1;
        end else if (lock_clear_ok) begin
            lock_bit_r <= 1'b0;
        end
    end

    // Persistent guard bits: program and erase need the lock bit at one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            persistent_sector_guard_bits <= 16'hffff;
        end else if (cmd_wr && reg_wr_ok && !busy_r && lock_bit_r) begin
            if (cmd_code == `CMD_GUARD_PROG) begin
                persistent_sector_guard_bits <= persistent_sector_guard_bits
                    & pwdata[31:16];
            end else if (cmd_code == `CMD_GUARD_ERASE) begin
                persistent_sector_guard_bits <= 16'hffff;
            end
        end
    end

    // Dynamic guard bits: plain register, refused under read guard
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dynamic_sector_guard_bits <= 16'hffff;
        end else if (guard_wr) begin
            dynamic_sector_guard_bits <= pwdata[15:0];
        end
    end

    // Fail flags: set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= '0;
        end else begin
            if (status_clr) begin
                flags_r <= '0;
            end
            if (set_both) begin
                flags_r <= '{sector_lock_fail_flag: 1'b1, program_fail_flag: 1'b1};
            end else if (set_prog) begin
                flags_r.program_fail_flag <= 1'b1;
            end
        end
    end

    // Address forcing path: sector bits pinned to the boot sector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_in_r <= '0;
            addr_out_r <= '0;
        end else begin
            if (addr_wr) begin
                addr_in_r <= pwdata[`ADDR_W-1:0];
            end
            addr_out_r <= addr_in_r;
            if (read_guard_on) begin
                addr_out_r[`SECT_LSB +: `SECT_W] <= {`SECT_W{boot_cfg_r[`BOOT_LO]}};
            end
        end
    end

    // Read mux; password visible only before secret lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= 32'h0000_0000;
            if (rd_en) begin
                case (paddr)
                    `OFF_MODE_CFG: prdata <= {16'h0000, mode_cfg_r};
                    `OFF_BOOT_CFG: prdata <= {16'h0000, boot_cfg_r};
                    `OFF_STATUS: prdata <= status_word;
                    `OFF_PWD_LO: prdata <= secret_locked ? 32'h0000_0000
                        : pwd_r[31:0];
                    `OFF_PWD_HI: prdata <= secret_locked ? 32'h0000_0000
                        : pwd_r[63:32];
                    // Undefined under read guard; zero chosen
                    `OFF_GUARD: prdata <= read_guard_on ? 32'h0000_0000
                        : {persistent_sector_guard_bits,
                        dynamic_sector_guard_bits};
                    `OFF_ADDR_OUT: prdata <= {6'h00, addr_out_r};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Zero-wait slave; unmapped access errors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr > `OFF_ADDR_OUT
                || paddr[1:0] != 2'b00);
        end
    end

endmodule : password_sector_protection

/* File: dv/psp_props.sv */
/*
 Port checker for password_sector_protection.
 Sees only the top ports; bound at the foot.
*/
`timescale 1ns/1ps
`include "pwd_guard_defs.svh"

module psp_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] persistent_sector_guard_bits,
    input wire logic [15:0] dynamic_sector_guard_bits
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Bus phases and decoded write targets
    logic bad;
    logic wr_cmd;
    logic wr_dyn;
    assign bad = paddr > `OFF_ADDR_OUT || paddr[1:0] != 2'b00;
    assign wr_cmd = psel && penable && pwrite && paddr == `OFF_CMD;
    assign wr_dyn = psel && penable && pwrite && paddr == `OFF_GUARD;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    property p_answer;
        s_setup |=> s_access;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    property p_one;
        pready |=> !pready;
    endproperty
    a_one: assert property (p_one) else $error("pready held too long");
    property p_cause;
        pready |-> $past(psel && !penable);
    endproperty
    a_cause: assert property (p_cause) else $error("pready without setup");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_bad;
        s_setup ##0 bad |=> pslverr;
    endproperty
    a_bad: assert property (p_bad) else $error("unmapped not flagged");
    property p_good;
        s_setup ##0 !bad |=> !pslverr;
    endproperty
    a_good: assert property (p_good) else $error("mapped flagged");
    property p_dyn;
        $changed(dynamic_sector_guard_bits) |-> $past(wr_dyn);
    endproperty
    a_dyn: assert property (p_dyn) else $error("dynamic bits moved");
    property p_pers;
        $changed(persistent_sector_guard_bits) |-> $past(wr_cmd);
    endproperty
    a_pers: assert property (p_pers) else $error("persistent bits moved");
endmodule : psp_props

bind password_sector_protection psp_props u_props (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .persistent_sector_guard_bits(persistent_sector_guard_bits),
    .dynamic_sector_guard_bits(dynamic_sector_guard_bits)
);

/* File: dv/apb_host.sv */
/*
 APB host model issuing register and command traffic.
 Assumes one pclk domain; the bench timeout ends any hang.
*/
`timescale 1ns/1ps
`include "pwd_guard_defs.svh"

module apb_host (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    logic [31:0] q;
    logic e;
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a; // No stale value once released
        pwdata <= ~d;
    endtask : xfer
    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task rd(input logic [11:0] a);
        xfer(1'b0, a, 32'h0000_0000);
    endtask : rd
    // Poll busy; a new unlock only once idle
    task wait_idle;
        do rd(`OFF_STATUS); while (q[`ST_BUSY] !== 1'b0);
    endtask : wait_idle
endmodule : apb_host

/* File: dv/password_sector_protection_tb.sv */
/*
 Self-checking bench for password_sector_protection.
 Assumes apb_host drives the bus and psp_props is bound.
*/
`timescale 1ns/1ps
`include "pwd_guard_defs.svh"

module password_sector_protection_tb;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] pbits;
    logic [15:0] dbits;
    logic [63:0] pw;
    logic [63:0] r2;
    logic [25:0] a;
    logic [1:0] code;
    int seed = 68;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    password_sector_protection dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .persistent_sector_guard_bits(pbits), .dynamic_sector_guard_bits(dbits));
    apb_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    // 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    // Hang guard, well above the six unlock intervals the bench runs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task cmd(input logic [3:0] c, input logic [15:0] d);
        host.wr(`OFF_CMD, {d, 12'h000, c});
    endtask : cmd
    task rchk(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] exp);
        host.rd(ad);
        chk(host.q & m, exp, "register");
    endtask : rchk
    // Halves in either order
    task stage(input logic [63:0] v, input bit hi_first);
        if (hi_first) host.wr(`OFF_PWD_HI, v[63:32]);
        host.wr(`OFF_PWD_LO, v[31:0]);
        if (!hi_first) host.wr(`OFF_PWD_HI, v[63:32]);
    endtask : stage
    // Sector bits forced to the boot end while guarded
    function logic [31:0] fwd(input logic [25:0] x, input logic [1:0] c, input bit on);
        return on ? {6'h00, {8{c[0]}}, x[17:0]} : {6'h00, x};
    endfunction : fwd
    task addr_chk(input logic [1:0] c, input bit on);
        a = 26'($random(seed));
        host.wr(`OFF_ADDR_IN, {6'h00, a});
        host.rd(`OFF_ADDR_OUT);
        chk(host.q, fwd(a, c, on), "addr out");
    endtask : addr_chk
    task unlock_ok;
        stage(pw, 1'b1);
        cmd(`CMD_UNLOCK, 16'h0000);
        rchk(`OFF_STATUS, 32'h0000_0101, 32'h0000_0001);
        repeat (4000) @(posedge pclk);
        rchk(`OFF_STATUS, 32'h0000_0101, 32'h0000_0001);
        host.wait_idle();
        rchk(`OFF_STATUS, 32'h0000_0300, 32'h0000_0100);
    endtask : unlock_ok
    // Main sequence
    initial begin
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`OFF_MODE_CFG, 32'h0000_ffff, 32'h0000_feff);
        rchk(`OFF_BOOT_CFG, 32'hffff_ffff, 32'h0000_0300);
        rchk(`OFF_STATUS, 32'h0000_0100, 32'h0000_0000);
        rchk(`OFF_PWD_LO, 32'hffff_ffff, 32'hffff_ffff);
        rchk(`OFF_PWD_HI, 32'hffff_ffff, 32'hffff_ffff);
        chk({pbits, dbits}, 32'hffff_ffff, "guard bits");
        host.rd(12'h024);
        chk({31'h0, host.e}, 32'h1, "pslverr");
        pw = {$random(seed), $random(seed)};
        stage(pw, 1'b0);
        cmd(`CMD_PWD_PROG, 16'h0000);
        r2 = {$random(seed), $random(seed)};
        stage(r2, 1'b1);
        cmd(`CMD_PWD_PROG, 16'h0000);
        pw = pw & r2;
        rchk(`OFF_PWD_LO, 32'hffff_ffff, pw[31:0]);
        rchk(`OFF_PWD_HI, 32'hffff_ffff, pw[63:32]);
        cmd(`CMD_BOOT_WRITE, 16'h0000);
        cmd(`CMD_MODE_PROG, 16'hfff9);
        rchk(`OFF_STATUS, 32'h0000_0012, 32'h0000_0012);
        rchk(`OFF_MODE_CFG, 32'h0000_ffff, 32'h0000_feff);
        host.wr(`OFF_STATUS, 32'h0000_0001);
        cmd(`CMD_MODE_PROG, 16'hffdb);
        rchk(`OFF_MODE_CFG, 32'h0000_ffff, 32'h0000_fedb);
        rchk(`OFF_STATUS, 32'h0000_0200, 32'h0000_0200);
        rchk(`OFF_PWD_LO, 32'hffff_ffff, 32'h0000_0000);
        addr_chk(2'b00, 1'b1);
        host.wr(`OFF_GUARD, 32'h0000_1234);
        cmd(`CMD_GUARD_PROG, 16'h00ff);
        cmd(`CMD_BOOT_WRITE, 16'h0300);
        chk({pbits, dbits}, 32'hffff_ffff, "guard bits");
        rchk(`OFF_BOOT_CFG, 32'hffff_ffff, 32'h0000_0000);
        stage(pw ^ 64'h1, 1'b0);
        cmd(`CMD_UNLOCK, 16'h0000);
        stage(pw, 1'b1);
        cmd(`CMD_UNLOCK, 16'h0000);
        host.wait_idle();
        rchk(`OFF_STATUS, 32'h0000_0110, 32'h0000_0010);
        for (int i = 0; i < 4; i++) begin
            code = 2'(i);
            unlock_ok();
            addr_chk(code, 1'b0);
            cmd(`CMD_BOOT_WRITE, {6'h00, code, 8'h00});
            rchk(`OFF_BOOT_CFG, 32'hffff_ffff, {22'h0, code, 8'h00});
            cmd(`CMD_LOCK_CLEAR, 16'h0000);
            rchk(`OFF_STATUS, 32'h0000_0300, 32'h0000_0200);
            addr_chk(code, 1'b1);
        end
        unlock_ok();
        cmd(`CMD_GUARD_PROG, 16'h00ff);
        @(posedge pclk);
        chk({16'h0, pbits}, 32'h0000_00ff, "persistent bits");
        cmd(`CMD_GUARD_ERASE, 16'h0000);
        @(posedge pclk);
        chk({16'h0, pbits}, 32'h0000_ffff, "persistent bits");
        host.wr(`OFF_STATUS, 32'h0000_0001);
        rchk(`OFF_STATUS, 32'h0000_0012, 32'h0000_0000);
        cmd(`CMD_PWD_PROG, 16'h0000);
        rchk(`OFF_STATUS, 32'h0000_0012, 32'h0000_0012);
        host.wr(`OFF_STATUS, 32'h0000_0001);
        cmd(`CMD_MODE_PROG, 16'hfffd);
        rchk(`OFF_STATUS, 32'h0000_0012, 32'h0000_0012);
        rchk(`OFF_MODE_CFG, 32'h0000_ffff, 32'h0000_fedb);
        host.wr(`OFF_GUARD, 32'h0000_1234);
        @(posedge pclk);
        chk({16'h0, dbits}, 32'h0000_1234, "dynamic bits");
        end_sim();
    end
endmodule : password_sector_protection_tb
